// >>> verilog/lmer_map.vh
// lmer_map.vh: register offsets, field positions, reset values, error
// codes and timing figures for the link message error reporter.
// assumes a 32-bit AHB-Lite register window with word-aligned registers.
`ifndef LMER_MAP_VH
`define LMER_MAP_VH

// register byte offsets
`define LMER_OFS_CH1_CODE 8'h00
`define LMER_OFS_CH2_CODE 8'h04
`define LMER_OFS_FLAGS 8'h08
`define LMER_OFS_CONFIG 8'h0C
`define LMER_OFS_CH1_TMO 8'h10
`define LMER_OFS_CH2_TMO 8'h14
`define LMER_OFS_IRQ_STAT 8'h18
`define LMER_OFS_IRQ_MASK 8'h1C

// config field positions
`define LMER_CFG_CLR_ON_RUN 0
`define LMER_CFG_STN_ALT 1
`define LMER_CFG_RESET 2'h0

// interrupt status layout: error flag events, then reject events
`define LMER_IRQ_ERR0 0
`define LMER_IRQ_NAK0 2
`define LMER_IRQ_W 4

// timeout setting reset value, in ticks (0 disables the monitor)
`define LMER_TMO_RESET 16'h000A

// reject codes sent back with a negative acknowledge
`define LMER_NAK_NONHEX 8'h07
`define LMER_NAK_STN 8'h10
`define LMER_NAK_STN_ALT 8'h0A
`define LMER_NAK_REMOTE 8'h18

// stored numeric error codes, as decimal values
`define LMER_C1_CHAR 16'd6301
`define LMER_C1_CMD 16'd6305
`define LMER_C1_TMO 16'd6306
`define LMER_C2_CHAR 16'd3801
`define LMER_C2_CMD 16'd3805
`define LMER_C2_TMO 16'd3806

// timing: one monitor tick, and the clock period
`define LMER_TICK_NS 1000000
`define LMER_CLK_NS 20
`define LMER_TICK_CYCLES (`LMER_TICK_NS / `LMER_CLK_NS)

// ahb transfer type with a live transfer in its top bit
`define LMER_HTRANS_NONSEQ 2'h2

`endif

// >>> verilog/lmer_top.v
// lmer_top.v: error detection and reporting for a two-channel ascii
// computer-link responder, with an ahb-lite register window.
// assumes the message parser runs on clk and gives one-cycle pulses;
// mode_run and mode_locked come from pins and are synchronised here.
//
// What this block does
// [RULE_01] reject sends nak with two ascii hex digits
// [RULE_02] simultaneous rejects report the lowest code
// [RULE_03] any reject resets the transfer sequence
// [RULE_04] non-hex write data rejected with 07H
// [RULE_05] missing station rejected with 10H or 0AH
// [RULE_06] remote run/stop under local selector gives 18H
// [RULE_07] erroneous message sets receiving channel's flag
// [RULE_08] channel one and two have separate flags
// [RULE_09] setting a flag stores its error code
// [RULE_10] character fault stores 6301 or 3801
// [RULE_11] station ff non-global command stores 6305/3805
// [RULE_12] receive timeout resets sequence, stores 6306/3806
// [RULE_13] good traffic never clears flags or codes
// [RULE_14] newer families clear only on power cycle
// [RULE_15] older families clear on stop-to-run change
// [RULE_16] timeout restarts per character, stops at end

`timescale 1ns/1ps
`include "lmer_map.vh"
`default_nettype none

module lmer_top #(
  parameter TICK_CYCLES = `LMER_TICK_CYCLES
)
(
  // clock and reset
  input wire clk,
  input wire reset,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // controller mode pins
  input wire mode_run,
  input wire mode_locked,
  // per-channel parser events, bit 0 is channel one
  input wire [1:0] rx_char_valid,
  input wire [1:0] rx_char_fault,
  input wire [1:0] msg_end,
  input wire [1:0] msg_nonhex_data,
  input wire [1:0] msg_station_missing,
  input wire [1:0] msg_station_ff,
  input wire [1:0] msg_cmd_global,
  input wire [1:0] msg_remote_mode_req,
  // per-channel answers to the link logic
  output wire [1:0] nak_valid,
  output wire [31:0] nak_chars, // per channel, high digit on top
  output wire [1:0] seq_reset,
  // error flags and codes for the local program
  output wire chan1_link_error_flag,
  output wire chan2_link_error_flag,
  output wire [15:0] chan1_link_error_code,
  output wire [15:0] chan2_link_error_code,
  // interrupt
  output wire irq
);

  // nibble to ascii hex character
  function [7:0] lmer_hex;
    input [3:0] n;
    begin
      lmer_hex = {4'h0, n} + ((n < 4'hA) ? 8'h30 : 8'h37);
    end
  endfunction

  // bus state
  reg [31:0] rdata; // read data, loaded in the address phase
  reg wr_pend; // write waiting for its data phase
  reg [7:0] wr_addr; // address of that write
  reg [1:0] config_bits; // clear-on-run and station code select
  reg [31:0] tmo_set; // timeout settings, ch2 in the high half
  reg [`LMER_IRQ_W-1:0] irq_stat; // sticky events
  reg [`LMER_IRQ_W-1:0] irq_mask; // enables onto irq
  reg irq_q; // registered interrupt line
  reg [1:0] bus_rsp; // hreadyout and hresp, kept as flops

  // per-channel state gathered for the bus
  wire [1:0] flag_w;
  wire [31:0] code_w;
  wire [1:0] err_evt;
  wire [1:0] nak_evt;
  // pin synchronisers and the run edge
  reg run_s1; // first stage, read only by run_s2
  reg run_s2;
  reg run_prev;
  reg lock_s1; // first stage, read only by lock_s2
  reg lock_s2;
  wire run_rise;
  // monitor tick divider
  reg [31:0] tick_cnt;
  reg tick;
  wire addr_ok;
  wire stat_w1c;
  assign addr_ok = hsel & hready & htrans[1];
  assign stat_w1c = wr_pend && (wr_addr == `LMER_OFS_IRQ_STAT);
  assign run_rise = run_s2 & ~run_prev;

  // two-flop synchronisers, then edge detect on the second stage
  always @(posedge clk)
  begin
    if (reset)
    begin
      run_s1 <= 1'b1;
      run_s2 <= 1'b1;
      run_prev <= 1'b1; // rests high: no false stop-to-run edge after reset
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
    end
    else
    begin
      run_s1 <= mode_run;
      run_s2 <= run_s1;
      run_prev <= run_s2;
      lock_s1 <= mode_locked;
      lock_s2 <= lock_s1;
    end
  end

  // free-running tick; the timeout only needs coarse resolution, so one
  // shared divider is traded for a small per-channel count
  always @(posedge clk)
  begin
    if (reset)
    begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b0;
    end
    else if (tick_cnt == TICK_CYCLES - 1)
    begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_ch
      reg flag; // sticky error flag
      reg [15:0] code; // last stored error code
      reg tmo_run; // monitor armed
      reg [15:0] tmo_cnt; // ticks since the last character
      reg nak_q; // reject pulse
      reg [15:0] nak_q_chars; // two ascii digits, high digit on top
      reg seq_q; // sequence reset pulse
      reg err_q; // flag-setting event, to the interrupt logic
      reg [7:0] next_nak;
      reg [15:0] next_code;
      wire [15:0] tmo_lim;
      wire tmo_hit;
      wire char_err;
      wire cmd_err;
      wire nak_any;
      assign tmo_lim = tmo_set[ch*16 +: 16];
      // zero setting disables the monitor
      assign tmo_hit = tmo_run & tick & (tmo_lim != 16'h0000) &
        (tmo_cnt + 16'h0001 >= tmo_lim); // [RULE_12]
      assign char_err = rx_char_valid[ch] & rx_char_fault[ch]; // [RULE_10]
      assign cmd_err = msg_end[ch] & msg_station_ff[ch] &
        ~msg_cmd_global[ch]; // [RULE_11]
      assign nak_any = msg_end[ch] & (msg_nonhex_data[ch] |
        msg_station_missing[ch] | (msg_remote_mode_req[ch] & lock_s2));
      // reject code, lowest number first
      always @*
      begin
        next_nak = 8'h00;
        if (msg_nonhex_data[ch])
          next_nak = `LMER_NAK_NONHEX; // [RULE_04] [RULE_02]
        else if (msg_station_missing[ch])
        begin
          if (config_bits[`LMER_CFG_STN_ALT])
            next_nak = `LMER_NAK_STN_ALT; // [RULE_05]
          else
            next_nak = `LMER_NAK_STN; // [RULE_05]
        end
        else if (msg_remote_mode_req[ch] & lock_s2)
          next_nak = `LMER_NAK_REMOTE; // [RULE_06]
      end

      // stored code, smallest first when events coincide
      always @*
      begin
        next_code = code;
        if (char_err)
          next_code = (ch == 0) ? `LMER_C1_CHAR : `LMER_C2_CHAR;
        else if (cmd_err)
          next_code = (ch == 0) ? `LMER_C1_CMD : `LMER_C2_CMD;
        else if (tmo_hit)
          next_code = (ch == 0) ? `LMER_C1_TMO : `LMER_C2_TMO;
      end

      // negative acknowledge and sequence reset
      always @(posedge clk)
      begin
        if (reset)
        begin
          nak_q <= 1'b0;
          nak_q_chars <= 16'h3030;
          seq_q <= 1'b0;
        end
        else
        begin
          nak_q <= nak_any; // [RULE_01]
          if (nak_any)
            nak_q_chars <= {lmer_hex(next_nak[7:4]),
              lmer_hex(next_nak[3:0])}; // [RULE_01]
          seq_q <= nak_any | tmo_hit; // [RULE_03] [RULE_12]
        end
      end

      // receive monitor: restart per character, stop at message end
      always @(posedge clk)
      begin
        if (reset)
        begin
          tmo_run <= 1'b0;
          tmo_cnt <= 16'h0000;
        end
        else if (rx_char_valid[ch])
        begin
          tmo_run <= 1'b1; // [RULE_16]
          tmo_cnt <= 16'h0000;
        end
        else if (msg_end[ch] | tmo_hit)
        begin
          tmo_run <= 1'b0; // [RULE_16]
          tmo_cnt <= 16'h0000;
        end
        else if (tmo_run & tick)
          tmo_cnt <= tmo_cnt + 16'h0001;
      end

      // sticky flag and code; only power-up reset or, on older families,
      // a stop-to-run edge clears them, and a new error wins over it
      always @(posedge clk)
      begin
        if (reset)
        begin
          flag <= 1'b0; // [RULE_14]
          code <= 16'h0000;
          err_q <= 1'b0;
        end
        else
        begin
          err_q <= char_err | cmd_err | tmo_hit;
          if (char_err | cmd_err | tmo_hit)
          begin
            flag <= 1'b1; // [RULE_07] [RULE_08]
            code <= next_code; // [RULE_09]
          end
          else if (run_rise & config_bits[`LMER_CFG_CLR_ON_RUN])
          begin
            flag <= 1'b0; // [RULE_15]
            code <= 16'h0000;
          end
          // good traffic falls through and leaves both alone [RULE_13]
        end
      end

      assign flag_w[ch] = flag;
      assign code_w[ch*16 +: 16] = code;
      assign err_evt[ch] = err_q;
      assign nak_evt[ch] = nak_q;
      assign nak_valid[ch] = nak_q;
      assign nak_chars[ch*16 +: 16] = nak_q_chars; // [RULE_01]
      assign seq_reset[ch] = seq_q;
    end
  endgenerate

  // ahb-lite slave: zero wait states, reads decoded in the address phase
  // so hrdata is a flop in the data phase; writes land in the data phase
  always @(posedge clk)
  begin
    if (reset)
    begin
      rdata <= 32'h00000000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      config_bits <= `LMER_CFG_RESET;
      tmo_set <= {`LMER_TMO_RESET, `LMER_TMO_RESET};
      irq_mask <= {`LMER_IRQ_W{1'b0}};
      bus_rsp <= 2'h2; // ready, okay
    end
    else
    begin
      bus_rsp <= 2'h2; // zero wait states, always okay
      wr_pend <= addr_ok & hwrite;
      wr_addr <= haddr;
      rdata <= 32'h00000000;
      // read decode; unmapped addresses read zero
      if (addr_ok & ~hwrite)
      begin
        case (haddr)
          `LMER_OFS_CH1_CODE: rdata <= {16'h0000, code_w[15:0]};
          `LMER_OFS_CH2_CODE: rdata <= {16'h0000, code_w[31:16]};
          `LMER_OFS_FLAGS: rdata <= {30'h0, flag_w};
          `LMER_OFS_CONFIG: rdata <= {30'h0, config_bits};
          `LMER_OFS_CH1_TMO: rdata <= {16'h0000, tmo_set[15:0]};
          `LMER_OFS_CH2_TMO: rdata <= {16'h0000, tmo_set[31:16]};
          `LMER_OFS_IRQ_STAT: rdata <= {28'h0000000, irq_stat};
          `LMER_OFS_IRQ_MASK: rdata <= {28'h0000000, irq_mask};
          default: rdata <= 32'h00000000;
        endcase
      end
      // write data phase; read-only and unmapped writes are dropped
      if (wr_pend)
      begin
        case (wr_addr)
          `LMER_OFS_CONFIG: config_bits <= hwdata[1:0];
          `LMER_OFS_CH1_TMO: tmo_set[15:0] <= hwdata[15:0];
          `LMER_OFS_CH2_TMO: tmo_set[31:16] <= hwdata[15:0];
          `LMER_OFS_IRQ_MASK: irq_mask <= hwdata[`LMER_IRQ_W-1:0];
          default: config_bits <= config_bits;
        endcase
      end
    end
  end

  // sticky interrupt status, write one to clear; a new event wins
  always @(posedge clk)
  begin
    if (reset)
    begin
      irq_stat <= {`LMER_IRQ_W{1'b0}};
      irq_q <= 1'b0;
    end
    else
    begin
      if (stat_w1c)
        irq_stat <= (irq_stat & ~hwdata[`LMER_IRQ_W-1:0]) |
          {nak_evt, err_evt};
      else
        irq_stat <= irq_stat | {nak_evt, err_evt};
      // one cycle behind the status bit, keeps the output a flop
      irq_q <= |(irq_stat & irq_mask);
    end
  end

  assign hrdata = rdata;
  assign hreadyout = bus_rsp[1];
  assign hresp = bus_rsp[0];
  assign irq = irq_q;
  assign chan1_link_error_flag = flag_w[0];
  assign chan2_link_error_flag = flag_w[1];
  assign chan1_link_error_code = code_w[15:0];
  assign chan2_link_error_code = code_w[31:16];

endmodule // lmer_top

`default_nettype wire

// >>> verification/lmer_chk_properties.sv
// lmer_chk_properties.sv: timing checks on the link error ports
// assumes binding to lmer_top; sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module lmer_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link events, bit 0 is channel one
  input wire logic [1:0] rx_char_valid,
  input wire logic [1:0] rx_char_fault,
  input wire logic [1:0] msg_end,
  input wire logic [1:0] msg_nonhex_data,
  input wire logic [1:0] msg_station_missing,
  input wire logic [1:0] msg_station_ff,
  input wire logic [1:0] msg_cmd_global,
  input wire logic [1:0] msg_remote_mode_req,
  input wire logic mode_run,
  // answers
  input wire logic [1:0] nak_valid,
  input wire logic [1:0] seq_reset,
  input wire logic chan1_link_error_flag,
  input wire logic chan2_link_error_flag,
  input wire logic [15:0] chan1_link_error_code
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // faulty character on channel one
  wire logic f0 = rx_char_valid[0] & rx_char_fault[0];
  // command-type fault: station ff without the global write
  wire logic m0 = msg_end[0] & msg_station_ff[0] & ~msg_cmd_global[0];

  AST_NONHEX_NAK: assert property (msg_end[0] && msg_nonhex_data[0]
    |=> nak_valid[0]) else $error("no reject on bad data");
  AST_STN_NAK: assert property (msg_end[0] && msg_station_missing[0]
    |=> nak_valid[0]) else $error("no reject on station");
  AST_NAK_SEQ: assert property (nak_valid[0] |-> seq_reset[0])
    else $error("reject without sequence reset");
  AST_GOOD_NO_NAK: assert property (msg_end[0] && !msg_nonhex_data[0]
    && !msg_station_missing[0] && !msg_remote_mode_req[0]
    |=> !nak_valid[0]) else $error("good message rejected");
  AST_CHAR_CODE: assert property (f0 |=> chan1_link_error_flag
    && chan1_link_error_code == 16'd6301)
    else $error("char fault not stored");
  AST_CMD_CODE: assert property (m0 && !f0
    |=> chan1_link_error_code == 16'd6305)
    else $error("command fault not stored");
  AST_CH2_FLAG: assert property (msg_end[1] && msg_station_ff[1]
    && !msg_cmd_global[1] |=> chan2_link_error_flag)
    else $error("channel two flag missing");
  AST_FLAG_HOLD: assert property ($fell(chan1_link_error_flag)
    |-> mode_run || $past(reset))
    else $error("flag lost without clear");
endmodule // lmer_chk

bind lmer_top lmer_chk u_chk (.clk(clk), .reset(reset),
  .rx_char_valid(rx_char_valid), .rx_char_fault(rx_char_fault),
  .msg_end(msg_end), .msg_nonhex_data(msg_nonhex_data),
  .msg_station_missing(msg_station_missing),
  .msg_station_ff(msg_station_ff), .msg_cmd_global(msg_cmd_global),
  .msg_remote_mode_req(msg_remote_mode_req), .mode_run(mode_run),
  .nak_valid(nak_valid), .seq_reset(seq_reset),
  .chan1_link_error_flag(chan1_link_error_flag),
  .chan2_link_error_flag(chan2_link_error_flag),
  .chan1_link_error_code(chan1_link_error_code));
`default_nettype wire

// >>> verification/lmer_host.sv
// lmer_host.sv: host model playing link characters and messages
// assumes the parser's one-cycle event pulses on the shared clock
`timescale 1ns/1ps
`default_nettype none
module lmer_host (
  // clock
  input wire logic clk,
  // parser events, bit 0 is channel one
  output logic [1:0] rx_char_valid = 2'h0,
  output logic [1:0] rx_char_fault = 2'h0,
  output logic [1:0] msg_end = 2'h0,
  output logic [1:0] msg_nonhex_data = 2'h0,
  output logic [1:0] msg_station_missing = 2'h0,
  output logic [1:0] msg_station_ff = 2'h0,
  output logic [1:0] msg_cmd_global = 2'h0,
  output logic [1:0] msg_remote_mode_req = 2'h0
);
  // one message; q is remote, global, ff, missing, nonhex
  task msg(input int c, input logic [4:0] q);
    @(posedge clk);
    msg_end[c] <= 1'b1;
    {msg_remote_mode_req[c], msg_cmd_global[c], msg_station_ff[c],
      msg_station_missing[c], msg_nonhex_data[c]} <= q;
    @(posedge clk);
    msg_end[c] <= 1'b0;
    // qualifiers lapse: show garbage so nothing leans on stale levels
    {msg_remote_mode_req[c], msg_cmd_global[c], msg_station_ff[c],
      msg_station_missing[c], msg_nonhex_data[c]} <= ~q;
  endtask
  // one received character, f marks a line fault
  task chr(input int c, input logic f);
    @(posedge clk);
    rx_char_valid[c] <= 1'b1;
    rx_char_fault[c] <= f;
    @(posedge clk);
    rx_char_valid[c] <= 1'b0;
    rx_char_fault[c] <= ~f;
  endtask
endmodule // lmer_host
`default_nettype wire

// >>> verification/tb.sv
// tb.sv: self-checking bench for the link message error reporter
// assumes lmer_top, lmer_host and the checker compile first
`timescale 1ns/1ps
`include "lmer_map.vh"
`default_nettype none
module tb;
  logic clk = 0, reset = 1, hsel = 0, hwrite = 0, mode_run = 1;
  logic mode_locked = 1;
  logic [7:0] haddr = 8'h00, c;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, rd, msk, seed = 32'd33490;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, irq, f1, f2;
  wire logic [1:0] cv, cf, me, nh, sm, sf, cg, rm, nv, sr;
  wire logic [31:0] nc;
  wire logic [15:0] c1, c2;
  int fails = 0, compares = 0, k, i, a;
  int ec[2];
  // reject cases: remote, global, ff, missing, nonhex
  logic [4:0] tbl[5] = '{5'h0D, 5'h0E, 5'h1C, 5'h1F, 5'h1E};
  always #10 clk = ~clk;
  lmer_top #(.TICK_CYCLES(4)) u_dut (.clk(clk), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mode_run(mode_run), .mode_locked(mode_locked),
    .rx_char_valid(cv), .rx_char_fault(cf), .msg_end(me),
    .msg_nonhex_data(nh), .msg_station_missing(sm),
    .msg_station_ff(sf), .msg_cmd_global(cg),
    .msg_remote_mode_req(rm), .nak_valid(nv), .nak_chars(nc),
    .seq_reset(sr), .chan1_link_error_flag(f1),
    .chan2_link_error_flag(f2), .chan1_link_error_code(c1),
    .chan2_link_error_code(c2), .irq(irq));
  lmer_host u_host (.clk(clk), .rx_char_valid(cv), .rx_char_fault(cf),
    .msg_end(me), .msg_nonhex_data(nh), .msg_station_missing(sm),
    .msg_station_ff(sf), .msg_cmd_global(cg),
    .msg_remote_mode_req(rm));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask
  task conclude;
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // wait for ready at rising edges, giving up after a bound
  task rdy;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && k < 50)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 50)
    begin
      fails++;
      conclude;
    end
  endtask
  // one single word transfer; read data lands in rd
  task bus(input logic [7:0] ad, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= `LMER_HTRANS_NONSEQ;
    haddr <= ad;
    hwrite <= w;
    rdy;
    @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  function logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // ascii hex digit of a nibble
  function logic [7:0] hx(input logic [3:0] n);
    return n < 10 ? 8'h30 + n : 8'h37 + n;
  endfunction
  initial
  begin
    ec = '{0, 0};
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    bus(`LMER_OFS_CH1_TMO, 0, 0);
    chk("tmo", rd, `LMER_TMO_RESET);
    bus(8'h20, 0, 0);
    chk("hole", rd, 0);
    chk("resp", hresp, 0);
    // every reject cause, then again with the alternate station code
    for (a = 0; a < 2; a++)
    begin
      bus(`LMER_OFS_CONFIG, 1, a << 1);
      for (i = 0; i < 5; i++)
      begin
        u_host.msg(0, tbl[i]);
        c = tbl[i][0] ? 8'h07 : tbl[i][1] ? (a ? 8'h0A : 8'h10) : 8'h18;
        @(negedge clk);
        chk("nak", {nv, sr}, 4'h5);
        chk("chars", nc[15:0], {hx(c[7:4]), hx(c[3:0])});
      end
    end
    u_host.msg(0, 5'h0C);
    @(negedge clk);
    chk("good", {nv, f1}, 3'h0);
    seed = xs(seed);
    msk = seed & 32'hF;
    bus(`LMER_OFS_IRQ_MASK, 1, seed);
    bus(`LMER_OFS_IRQ_MASK, 0, 0);
    chk("mask", rd, msk);
    u_host.chr(0, 1);
    ec[0] = 6301;
    cyc(3);
    chk("code1", {f1, c1}, {1'b1, ec[0][15:0]});
    chk("irq", irq, msk[0] | msk[2]);
    // clean traffic afterwards must leave the record alone
    u_host.chr(0, 0);
    u_host.msg(0, 5'h0C);
    bus(`LMER_OFS_CH1_CODE, 0, 0);
    chk("keep1", rd, ec[0]);
    u_host.msg(1, 5'h04);
    ec[1] = 3805;
    cyc(2);
    chk("code2", {c2, c1}, {ec[1][15:0], ec[0][15:0]});
    bus(`LMER_OFS_FLAGS, 0, 0);
    chk("flags", rd, 3);
    bus(`LMER_OFS_IRQ_STAT, 1, 32'hF);
    cyc(3);
    chk("irqclr", irq, 0);
    // newer family keeps the record over stop-to-run, older clears it
    for (a = 0; a < 2; a++)
    begin
      bus(`LMER_OFS_CONFIG, 1, a);
      @(posedge clk) mode_run <= 1'b0;
      cyc(4);
      @(posedge clk) mode_run <= 1'b1;
      cyc(4);
      chk("clr", {f1, f2, c1}, a ? 0 : {2'h3, ec[0][15:0]});
    end
    bus(`LMER_OFS_CH1_TMO, 1, 2);
    u_host.chr(0, 0);
    k = 0;
    while (sr[0] !== 1'b1 && k < 60)
    begin
      @(negedge clk);
      k++;
    end
    chk("tmoseq", sr[0], 1);
    cyc(1);
    chk("tmocode", c1, 6306);
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    cyc(1);
    chk("por", {f1, c1}, 0);
    conclude;
  end
endmodule // tb
`default_nettype wire
